// File: src/wsq_pkg.sv
// Purpose: shared constants, types and register map of the sequence player
// Assumes: one 100 MHz sample clock, synchronous active-low reset
// Notes:   eight waveform segments, up to sixteen sequence entries
package wsq_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int          WSQ_CLK_NS     = 10;
    localparam int          WSQ_MS_NS      = 1000000;
    localparam int          WSQ_CYC_PER_MS = (WSQ_MS_NS + WSQ_CLK_NS - 1) / WSQ_CLK_NS;
    localparam logic [15:0] WSQ_EXT_DLY_MS = 16'h0064;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int WSQ_SEG_W = 3;
    localparam int WSQ_ENT_W = 4;
    localparam int WSQ_MEM_W = WSQ_SEG_W + 4;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] WSQ_OFS_CTRL   = 8'h00;
    localparam logic [7:0] WSQ_OFS_DLY    = 8'h04;
    localparam logic [7:0] WSQ_OFS_VOL    = 8'h08;
    localparam logic [7:0] WSQ_OFS_CMD    = 8'h0c;
    localparam logic [7:0] WSQ_OFS_ENTRY  = 8'h10;
    localparam logic [7:0] WSQ_OFS_RFIRST = 8'h14;
    localparam logic [7:0] WSQ_OFS_RLAST  = 8'h18;
    localparam logic [7:0] WSQ_OFS_RSKIP  = 8'h1c;
    localparam logic [7:0] WSQ_OFS_SEGLEN = 8'h20;
    localparam logic [7:0] WSQ_OFS_STATUS = 8'h24;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int WSQ_CTRL_EN    = 0;
    localparam int WSQ_CTRL_MODE  = 1;
    localparam int WSQ_CTRL_SRC   = 3;
    localparam int WSQ_CTRL_POL   = 4;
    localparam int WSQ_CTRL_DLYEN = 5;
    localparam int WSQ_CMD_NEW    = 0;
    localparam int WSQ_CMD_APPEND = 1;
    localparam int WSQ_CMD_SEG    = 4;
    localparam int WSQ_ENT_IDX    = 8;
    localparam int WSQ_SKIP_MASK  = 8;
    localparam int WSQ_LEN_SEG    = 16;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [5:0] WSQ_CTRL_RST = 6'h10;
    localparam logic [3:0] WSQ_MKR_RST  = 4'h3;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        WSQ_MODE_SINGLE = 2'h0,
        WSQ_MODE_GATED  = 2'h1,
        WSQ_MODE_SEGADV = 2'h2,
        WSQ_MODE_EXT    = 2'h3
    } wsq_mode_t;

    typedef enum logic [1:0] {
        WSQ_ST_IDLE  = 2'h0,
        WSQ_ST_ARM   = 2'h1,
        WSQ_ST_FETCH = 2'h3,
        WSQ_ST_PLAY  = 2'h2
    } wsq_st_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } wsq_bus_t;

    typedef struct packed {
        logic                 play;
        logic [WSQ_SEG_W-1:0] seg;
        logic [15:0]          point;
        logic [3:0]           ev;
    } wsq_out_t;

endpackage

// File: src/wsq_seq_mem.sv
// Purpose: sequence entry store, one segment number and four marker enables each
// Assumes: write mask lets the marker field change without touching the segment
// Notes:   read data registered, one cycle after the address
module wsq_seq_mem #(
    parameter int AW = 4,
    parameter int DW = 7
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    // write side
    input  wire logic [1:0]    we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // read side
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    typedef struct packed {
        logic [(1<<AW)-1:0][DW-1:0] mem;
        logic [DW-1:0]              rd;
    } wsq_mem_state_t;

    wsq_mem_state_t m_q;
    wsq_mem_state_t m_d;

    always_comb begin
        m_d = m_q;
        // low four bits are the marker lanes, the rest the segment
        if (we[0]) begin
            m_d.mem[waddr][3:0] = wdata[3:0];
        end
        if (we[1]) begin
            m_d.mem[waddr][DW-1:4] = wdata[DW-1:4];
        end
        m_d.rd = m_q.mem[raddr];
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            m_q <= '0;
        end else begin
            m_q <= m_d;
        end
    end

    assign rdata = m_q.rd;
endmodule

// File: src/wsq_player.sv
// Purpose: waveform sequence player with per-entry markers and triggers
// Assumes: inputs synchronous, segment lengths loaded before playback
// Notes:   one sample per clock while playing
module wsq_player #(
    parameter int CYC_PER_MS = wsq_pkg::WSQ_CYC_PER_MS
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    // register port
    input  wsq_pkg::wsq_bus_t bus,
    output logic [31:0]     rdata,
    // trigger inputs
    input  wire logic       trig_key,
    input  wire logic       pattern_trigger_input,
    // playback
    output wsq_pkg::wsq_out_t play_out
);
    import wsq_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    localparam logic [16:0] MS_LAST = 17'(CYC_PER_MS - 1);
    localparam logic [4:0]  DEPTH   = 5'(1 << WSQ_ENT_W);

    typedef struct packed {
        wsq_st_t                st;
        logic [5:0]             ctrl;
        logic [15:0]            dly_ms;
        logic [7:0]             vol;
        logic [4:0]             seqlen;
        logic                   refused;
        logic [3:0]             last_mkr;
        logic [15:0]            rfirst;
        logic [15:0]            rlast;
        logic [7:0]             skip;
        logic [3:0]             rmask;
        logic [7:0][15:0]       len;
        logic [WSQ_ENT_W-1:0]   entry;
        logic [WSQ_SEG_W-1:0]   cur_seg;
        logic [3:0]             cur_mkr;
        logic [7:0]             sk;
        logic [2:0]             key_s;
        logic [2:0]             ext_s;
        logic                   busy;
        logic [16:0]            ms_cnt;
        logic [15:0]            dly_cnt;
        wsq_out_t               out;
        logic [31:0]            rd;
    } wsq_state_t;

    wsq_state_t           s_q;
    wsq_state_t           s_d;
    logic [1:0]           mem_we;
    logic [WSQ_ENT_W-1:0] mem_waddr;
    logic [WSQ_MEM_W-1:0] mem_wdata;
    logic [WSQ_MEM_W-1:0] mem_rdata;
    logic                 src_edge;
    logic                 gate;
    logic                 fire;
    logic                 app_ok;
    logic [WSQ_ENT_W-1:0] nxt_entry;
    logic                 wrap;

    wire wsq_mode_t mode  = wsq_mode_t'(s_q.ctrl[WSQ_CTRL_MODE +: 2]);
    wire logic      en    = s_q.ctrl[WSQ_CTRL_EN];
    wire logic      dlyen = s_q.ctrl[WSQ_CTRL_DLYEN];

    function automatic logic [15:0] clamp_last(logic [15:0] first, logic [15:0] last);
        clamp_last = (last < first) ? first : last;
    endfunction

    // ************************************************************
    // entry store
    // ************************************************************
    wsq_seq_mem #(
        .AW (WSQ_ENT_W),
        .DW (WSQ_MEM_W)
    ) u_mem (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (s_d.entry),
        .rdata   (mem_rdata)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [15:0]          np;
        logic [15:0]          last_pt;
        logic                 adv;
        logic                 rhit;
        logic [WSQ_SEG_W-1:0] wseg;
        np        = s_q.out.point;
        last_pt   = 16'h0000;
        adv       = 1'b0;
        rhit      = 1'b0;
        wseg      = bus.wdata[WSQ_CMD_SEG +: WSQ_SEG_W];
        s_d       = s_q;
        mem_we    = 2'h0;
        mem_waddr = s_q.seqlen[WSQ_ENT_W-1:0];
        mem_wdata = {wseg, s_q.last_mkr};
        app_ok    = 1'b0;
        fire      = 1'b0;

        // register reads, data stand one cycle later
        s_d.rd = 32'h0000_0000;
        if (bus.rd) begin
            if (bus.addr == WSQ_OFS_CTRL) begin
                s_d.rd = {26'h0, s_q.ctrl};
            end else if (bus.addr == WSQ_OFS_DLY) begin
                s_d.rd = {16'h0, s_q.dly_ms};
            end else if (bus.addr == WSQ_OFS_VOL) begin
                s_d.rd = {24'h0, s_q.vol};
            end else if (bus.addr == WSQ_OFS_ENTRY) begin
                s_d.rd = {28'h0, s_q.last_mkr};
            end else if (bus.addr == WSQ_OFS_RFIRST) begin
                s_d.rd = {16'h0, s_q.rfirst};
            end else if (bus.addr == WSQ_OFS_RLAST) begin
                s_d.rd = {16'h0, s_q.rlast};
            end else if (bus.addr == WSQ_OFS_RSKIP) begin
                s_d.rd = {20'h0, s_q.rmask, s_q.skip};
            end else if (bus.addr == WSQ_OFS_STATUS) begin
                s_d.rd = {13'h0, s_q.cur_seg, 3'h0, s_q.seqlen,
                          s_q.entry, 1'b0, s_q.st == WSQ_ST_ARM,
                          s_q.refused, s_q.out.play};
            end
        end

        // register writes
        if (bus.wr) begin
            if (bus.addr == WSQ_OFS_CTRL) begin
                s_d.ctrl = bus.wdata[5:0];
            end else if (bus.addr == WSQ_OFS_DLY) begin
                s_d.dly_ms = bus.wdata[15:0];
            end else if (bus.addr == WSQ_OFS_VOL) begin
                s_d.vol = bus.wdata[7:0];
            end else if (bus.addr == WSQ_OFS_CMD) begin
                if (bus.wdata[WSQ_CMD_NEW]) begin
                    s_d.seqlen  = 5'h00;
                    s_d.refused = 1'b0;
                end else if (bus.wdata[WSQ_CMD_APPEND]) begin
                    // same segment may land in many entries, each its own
                    if (s_q.vol[wseg] && s_q.seqlen < DEPTH) begin
                        app_ok     = 1'b1;
                        mem_we     = 2'h3;
                        s_d.seqlen = s_q.seqlen + 5'h01;
                    end else begin
                        s_d.refused = 1'b1;
                    end
                end
            end else if (bus.addr == WSQ_OFS_ENTRY) begin
                // only the marker lanes of the one addressed entry change
                if ({1'b0, bus.wdata[WSQ_ENT_IDX +: WSQ_ENT_W]} < s_q.seqlen) begin
                    mem_we    = 2'h1;
                    mem_waddr = bus.wdata[WSQ_ENT_IDX +: WSQ_ENT_W];
                    mem_wdata = {wseg, bus.wdata[3:0]};
                end
                s_d.last_mkr = bus.wdata[3:0];
            end else if (bus.addr == WSQ_OFS_RFIRST) begin
                s_d.rfirst = bus.wdata[15:0];
                s_d.rlast  = clamp_last(bus.wdata[15:0], s_q.rlast);
            end else if (bus.addr == WSQ_OFS_RLAST) begin
                s_d.rlast = clamp_last(s_q.rfirst, bus.wdata[15:0]);
            end else if (bus.addr == WSQ_OFS_RSKIP) begin
                s_d.skip  = bus.wdata[7:0];
                s_d.rmask = bus.wdata[WSQ_SKIP_MASK +: 4];
            end else if (bus.addr == WSQ_OFS_SEGLEN) begin
                s_d.len[bus.wdata[WSQ_LEN_SEG +: WSQ_SEG_W]] = bus.wdata[15:0];
            end
        end

        // triggers: edges seen only past the second stage
        s_d.key_s = {s_q.key_s[1:0], trig_key};
        s_d.ext_s = {s_q.ext_s[1:0], pattern_trigger_input};
        if (s_q.ctrl[WSQ_CTRL_SRC]) begin
            src_edge = s_q.ctrl[WSQ_CTRL_POL] ? (s_q.ext_s[1] & ~s_q.ext_s[2])
                                              : (~s_q.ext_s[1] & s_q.ext_s[2]);
            gate     = s_q.ext_s[1] ~^ s_q.ctrl[WSQ_CTRL_POL];
        end else begin
            src_edge = s_q.key_s[1] & ~s_q.key_s[2];
            gate     = s_q.key_s[1];
        end

        // optional delay, edges during a running delay are dropped
        if (s_q.busy) begin
            if (s_q.ms_cnt == MS_LAST) begin
                s_d.ms_cnt = 17'h00000;
                if (s_q.dly_cnt <= 16'h0001) begin
                    s_d.busy = 1'b0;
                    fire     = 1'b1;
                end else begin
                    s_d.dly_cnt = s_q.dly_cnt - 16'h0001;
                end
            end else begin
                s_d.ms_cnt = s_q.ms_cnt + 17'h00001;
            end
        end else if (src_edge) begin
            if (dlyen && s_q.dly_ms != 16'h0000) begin
                s_d.busy    = 1'b1;
                s_d.dly_cnt = s_q.dly_ms;
                s_d.ms_cnt  = 17'h00000;
            end else begin
                fire = 1'b1;
            end
        end

        // sequencing
        wrap      = ({1'b0, s_q.entry} + 5'h01) >= s_q.seqlen;
        nxt_entry = wrap ? '0 : s_q.entry + 1'b1;
        last_pt   = (s_q.len[s_q.cur_seg] == 16'h0000) ? 16'h0000
                                                       : s_q.len[s_q.cur_seg] - 16'h0001;
        case (s_q.st)
            WSQ_ST_IDLE: begin
                if (en && s_q.seqlen != 5'h00) begin
                    s_d.entry = '0;
                    if (mode == WSQ_MODE_SINGLE || mode == WSQ_MODE_EXT) begin
                        s_d.st = WSQ_ST_ARM;
                    end else begin
                        s_d.st = WSQ_ST_FETCH;
                    end
                end
            end
            WSQ_ST_ARM: begin
                if (fire) begin
                    s_d.entry = '0;
                    s_d.st    = WSQ_ST_FETCH;
                end
            end
            WSQ_ST_FETCH: begin
                s_d.cur_seg = mem_rdata[WSQ_MEM_W-1:4];
                s_d.cur_mkr = mem_rdata[3:0];
                s_d.sk      = 8'h00;
                np          = 16'h0000;
                adv         = 1'b1;
                s_d.st      = WSQ_ST_PLAY;
            end
            WSQ_ST_PLAY: begin
                if (mode == WSQ_MODE_SEGADV && fire) begin
                    s_d.entry = nxt_entry;
                    s_d.st    = WSQ_ST_FETCH;
                end else if (mode != WSQ_MODE_GATED || gate) begin
                    if (s_q.out.point >= last_pt) begin
                        // at a segment's last sample: segment advance replays it, single re-arms after the last entry, others take the next
                        if (mode == WSQ_MODE_SEGADV) begin
                            np  = 16'h0000;
                            adv = 1'b1;
                        end else if (mode == WSQ_MODE_SINGLE && wrap) begin
                            s_d.st = WSQ_ST_ARM;
                        end else begin
                            s_d.entry = nxt_entry;
                            s_d.st    = WSQ_ST_FETCH;
                        end
                    end else begin
                        np  = s_q.out.point + 16'h0001;
                        adv = 1'b1;
                    end
                end
            end
            default: begin
                s_d.st = WSQ_ST_IDLE;
            end
        endcase
        if (!en) begin
            s_d.st   = WSQ_ST_IDLE;
            s_d.busy = 1'b0;
        end

        // range marker: one marked point, then skip points
        if (adv && np >= s_q.rfirst && np <= s_q.rlast) begin
            if (np == s_q.rfirst || s_d.sk == 8'h00) begin
                rhit   = 1'b1;
                s_d.sk = s_q.skip;
            end else begin
                s_d.sk = s_d.sk - 8'h01;
            end
        end

        // outputs registered with the sample they belong to
        s_d.out.play  = adv;
        s_d.out.seg   = s_d.cur_seg;
        s_d.out.point = np;
        for (int m = 0; m < 4; m++) begin
            s_d.out.ev[m] = adv && s_d.cur_mkr[m] &&
                            ((np == 16'h0000 && m < 2) || (rhit && s_q.rmask[m]));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_q          <= '0;
            s_q.ctrl     <= WSQ_CTRL_RST;
            s_q.dly_ms   <= WSQ_EXT_DLY_MS;
            s_q.last_mkr <= WSQ_MKR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata    = s_q.rd;
    assign play_out = s_q.out;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    AST_EVENT_GATED: assert property ((s_q.out.ev & ~s_q.cur_mkr) == 4'h0)
        else $error("event without its marker enable");
    AST_FIRST_POINT: assert property (s_q.out.play && s_q.out.point == 16'h0000
        && s_q.cur_mkr[1:0] == 2'h3 |-> s_q.out.ev[1:0] == 2'h3)
        else $error("markers one and two missing on first point");
    AST_APPEND_REFUSE: assert property (bus.wr && bus.addr == WSQ_OFS_CMD
        && bus.wdata[WSQ_CMD_APPEND] && !bus.wdata[WSQ_CMD_NEW]
        && !s_q.vol[bus.wdata[WSQ_CMD_SEG +: WSQ_SEG_W]]
        |=> $stable(s_q.seqlen) && s_q.refused)
        else $error("append of absent segment accepted");
    AST_APPEND_GROW: assert property (app_ok |-> mem_wdata[3:0] == s_q.last_mkr
        ##1 s_q.seqlen == $past(s_q.seqlen) + 5'h01)
        else $error("append did not add one entry with last markers");
    AST_RANGE_ORDER: assert property (s_q.rlast >= s_q.rfirst)
        else $error("range last point below first");
    AST_START_FIRST: assert property ($rose(en) && s_q.st == WSQ_ST_IDLE
        && s_q.seqlen != 5'h00 && mode == WSQ_MODE_SEGADV
        ##1 en |-> ##1 s_q.out.play && s_q.out.point == 16'h0000 && s_q.entry == '0)
        else $error("playback did not start on first entry");
    AST_SEG_ADVANCE: assert property (s_q.st == WSQ_ST_PLAY && en
        && mode == WSQ_MODE_SEGADV && fire
        |=> s_q.st == WSQ_ST_FETCH && s_q.entry == $past(nxt_entry))
        else $error("advance trigger did not select next entry");
    AST_NO_DELAY: assert property (s_q.st == WSQ_ST_ARM && en && !s_q.busy
        && src_edge && !dlyen |=> s_q.st == WSQ_ST_FETCH)
        else $error("undelayed trigger did not start playback");
    AST_DELAY_LOAD: assert property (s_q.st == WSQ_ST_ARM && en && !s_q.busy
        && src_edge && dlyen && s_q.dly_ms != 16'h0000
        |=> s_q.busy && s_q.st == WSQ_ST_ARM && s_q.dly_cnt == $past(s_q.dly_ms))
        else $error("delayed trigger started early");

    CVR_SEG_ADVANCE: cover property (s_q.st == WSQ_ST_PLAY && mode == WSQ_MODE_SEGADV && fire);
    CVR_DELAY_FIRE:  cover property (s_q.busy && fire);
    CVR_REFUSED:     cover property ($rose(s_q.refused));
    CVR_GATE_PAUSE:  cover property (s_q.st == WSQ_ST_PLAY && mode == WSQ_MODE_GATED && !gate);
endmodule

// File: tb/wsq_trig_src.sv
// Purpose: trigger key and external TTL trigger source in front of the player
// Assumes: levels change only just after a rising clock edge
// Notes:   TTL line is always driven by the source, never released
module wsq_trig_src (
    // clock
    input  wire logic sys_clk,
    // trigger lines
    output logic      trig_key,
    output logic      pattern_trigger_input
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        trig_key = 1'b0;
        pattern_trigger_input = 1'b0;
    end

    // levels held until the next call, so edges are as clean as a real generator
    task automatic set_lines(input logic k, input logic e);
        @(posedge sys_clk);
        trig_key <= k;
        pattern_trigger_input <= e;
    endtask
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for the sequence player
// Assumes: CYC_PER_MS shortened to 4, so DLY=2 means 8 cycles
// Notes:   delay windows leave a few cycles of slack for the synchroniser
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wsq_pkg::*;

    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    wsq_bus_t    bus     = '0;
    logic [31:0] rdata;
    logic        trig_key;
    logic        pattern_trigger_input;
    wsq_out_t    play_out;
    int          err_total = 0;
    int          total_checks = 0;
    int          n;

    always #5 sys_clk = ~sys_clk;

    wsq_player #(.CYC_PER_MS(4)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .bus(bus), .rdata(rdata), .trig_key(trig_key),
        .pattern_trigger_input(pattern_trigger_input), .play_out(play_out));

    wsq_trig_src src (
        .sys_clk(sys_clk), .trig_key(trig_key), .pattern_trigger_input(pattern_trigger_input));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        check(rdata & m, e);
    endtask

    // cycles until a sample appears, capped at lim
    task automatic waitp(input int lim, output int c);
        c = 0;
        while (play_out.play !== 1'b1 && c < lim) begin
            @(posedge sys_clk);
            #1;
            c++;
        end
    endtask

    // first point of the playing entry: segment and events
    task automatic pt0(input logic [2:0] s, input logic [3:0] e);
        int c;
        c = 0;
        do begin
            @(posedge sys_clk);
            #1;
            c++;
        end while (!(play_out.play === 1'b1 && play_out.point === 16'h0) && c < 40);
        check({29'h0, play_out.seg}, {29'h0, s});
        check({28'h0, play_out.ev}, {28'h0, e});
    endtask

    task automatic key_pulse();
        src.set_lines(1'b1, 1'b0);
        repeat (3) @(posedge sys_clk);
        src.set_lines(1'b0, 1'b0);
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic give_verdict();
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(WSQ_OFS_CTRL, 32'h3f, 32'h10);
        rd(WSQ_OFS_DLY, 32'hffff, 32'h64);
        rd(WSQ_OFS_ENTRY, 32'hf, 32'h3);
        rd(8'h3c, 32'hffffffff, 32'h0);
        wr(WSQ_OFS_VOL, 32'h3);
        wr(WSQ_OFS_SEGLEN, 32'h0000_0004);
        wr(WSQ_OFS_SEGLEN, 32'h0001_0003);
        wr(WSQ_OFS_CMD, 32'h1);
        wr(WSQ_OFS_CMD, 32'h2);
        wr(WSQ_OFS_CMD, 32'h2);
        wr(WSQ_OFS_CMD, 32'h22);
        rd(WSQ_OFS_STATUS, 32'h1f02, 32'h0202);
        wr(WSQ_OFS_ENTRY, 32'h101);
        rd(WSQ_OFS_ENTRY, 32'hf, 32'h1);
        wr(WSQ_OFS_CMD, 32'h12);
        rd(WSQ_OFS_STATUS, 32'h1f00, 32'h0300);
        wr(WSQ_OFS_RFIRST, 32'h5);
        wr(WSQ_OFS_RLAST, 32'h2);
        rd(WSQ_OFS_RLAST, 32'hffff, 32'h5);
        // segment advance from the key; entry 0 kept 0x3 after entry 1 was edited
        wr(WSQ_OFS_CTRL, 32'h15);
        pt0(3'h0, 4'h3);
        key_pulse();
        pt0(3'h0, 4'h1);
        key_pulse();
        pt0(3'h1, 4'h1);
        // range on points 1..3, one skipped, markers three and four on entry 0
        wr(WSQ_OFS_CTRL, 32'h0);
        wr(WSQ_OFS_ENTRY, 32'h00c);
        wr(WSQ_OFS_RFIRST, 32'h1);
        wr(WSQ_OFS_RLAST, 32'h3);
        wr(WSQ_OFS_RSKIP, 32'h0c01);
        rd(WSQ_OFS_RSKIP, 32'hfff, 32'hc01);
        wr(WSQ_OFS_CTRL, 32'h15);
        pt0(3'h0, 4'h0);
        for (int i = 1; i < 4; i++) begin
            @(posedge sys_clk);
            #1;
            check({12'h0, play_out.point, play_out.ev}, {12'h0, 16'(i), (i == 2) ? 4'h0 : 4'hc});
        end
        // gated by the key level
        wr(WSQ_OFS_CTRL, 32'h0);
        wr(WSQ_OFS_CTRL, 32'h13);
        repeat (10) @(posedge sys_clk);
        #1;
        check({31'h0, play_out.play}, 32'h0);
        src.set_lines(1'b1, 1'b0);
        waitp(8, n);
        check({31'h0, n < 8}, 32'h1);
        // single, external, rising, delay 2 ms = 8 cycles
        wr(WSQ_OFS_CTRL, 32'h0);
        src.set_lines(1'b0, 1'b1);
        wr(WSQ_OFS_DLY, 32'h2);
        wr(WSQ_OFS_CTRL, 32'h39);
        src.set_lines(1'b0, 1'b0);
        waitp(20, n);
        check({31'h0, n == 20}, 32'h1);
        src.set_lines(1'b0, 1'b1);
        waitp(40, n);
        check({31'h0, n >= 8 && n <= 16}, 32'h1);
        // same without the delay enable, then external looping mode
        wr(WSQ_OFS_CTRL, 32'h0);
        src.set_lines(1'b0, 1'b0);
        wr(WSQ_OFS_CTRL, 32'h19);
        src.set_lines(1'b0, 1'b1);
        waitp(40, n);
        check({31'h0, n >= 2 && n <= 7}, 32'h1);
        wr(WSQ_OFS_CTRL, 32'h0);
        src.set_lines(1'b0, 1'b0);
        wr(WSQ_OFS_CTRL, 32'h1f);
        src.set_lines(1'b0, 1'b1);
        waitp(40, n);
        check({31'h0, n <= 7}, 32'h1);
        // single, external, falling polarity: rising edge ignored, falling starts
        src.set_lines(1'b0, 1'b0);
        wr(WSQ_OFS_CTRL, 32'h0);
        wr(WSQ_OFS_CTRL, 32'h09);
        src.set_lines(1'b0, 1'b1);
        waitp(20, n);
        check({31'h0, n == 20}, 32'h1);
        src.set_lines(1'b0, 1'b0);
        waitp(40, n);
        check({31'h0, n >= 2 && n <= 7}, 32'h1);
        give_verdict();
    end

    // whole run is a few hundred cycles; this is ample margin
    initial begin
        #100us;
        err_total++;
        give_verdict();
    end
endmodule
